// ### bench/sbt_socket_buffer_bench.sv
// Purpose: Self-checking bench of the socket buffer block
// Assumes: Byte register access, sink model on the transmit stream
// Notes: Default 2KB sizes put socket bases 2KB apart
`timescale 1ns/100ps
`default_nettype none
module sbt_socket_buffer_bench;
   logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, open = 1'b0, send = 1'b0, sync = 1'b0;
   logic mss_ld = 1'b0, ack_ld = 1'b0, bwr = 1'b0, map_req = 1'b0;
   logic rvalid, map_valid, tvalid, tready, busy, done;
   logic [2:0] rsock = 3'h0, csock = 3'h0, bsock = 3'h0, msock = 3'h0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, bdata = 8'h00, rdata, tdata, tos, ttl;
   logic [15:0] pmss = 16'h0000, ackp = 16'h0000, boff = 16'h0000, moff = 16'h0000;
   logic [13:0] maddr;
   logic [3:0] stall = 4'h0;
   logic [7:0] ra [8] = '{8'h15, 8'h16, 8'h1e, 8'h1f, 8'h20, 8'h21, 8'h12, 8'h30};
   logic [7:0] re [8] = '{8'h00, 8'h80, 8'h02, 8'h02, 8'h08, 8'h00, 8'h00, 8'h00};
   logic [7:0] codes [6] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10};
   logic [7:0] exp_b [4] = '{8'ha0, 8'ha1, 8'ha2, 8'hc3};
   int error_cnt = 0, checks = 0;
   always #2.5 clk = ~clk;
   sbt_socket_buffer dut (.core_clk_in(clk), .rstn_in(rstn), .reg_sock_in(rsock),
      .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
      .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .cmd_sock_in(csock), .cmd_open_in(open),
      .cmd_send_in(send), .tcp_sync_in(sync), .peer_mss_load_in(mss_ld), .peer_mss_in(pmss),
      .ack_ptr_load_in(ack_ld), .ack_ptr_in(ackp), .buf_wr_in(bwr), .buf_sock_in(bsock),
      .buf_offset_in(boff), .buf_wdata_in(bdata), .rx_map_req_in(map_req),
      .rx_map_sock_in(msock), .rx_map_offset_in(moff), .rx_map_addr_out(maddr),
      .rx_map_valid_out(map_valid), .tx_data_out(tdata), .tx_valid_out(tvalid),
      .tx_ready_in(tready), .tx_busy_out(busy), .send_done_out(done), .tx_tos_out(tos),
      .tx_ttl_out(ttl));
   sbt_stream_sink sink (.clk_in(clk), .rstn_in(rstn), .data_in(tdata), .valid_in(tvalid),
      .stall_in(stall), .ready_out(tready));
   // ----------------------------------------------------------------
   // Bus and compare tasks
   // ----------------------------------------------------------------
   task automatic chk(input string name, input logic [15:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wreg(input logic [2:0] s, input logic [7:0] a, d);
      @(posedge clk);
      {rsock, addr, wdata, wr} <= {s, a, d, 1'b1};
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic w16(input logic [2:0] s, input logic [7:0] a, input logic [15:0] v);
      wreg(s, a, v[15:8]);
      wreg(s, a + 8'h01, v[7:0]);
   endtask
   // Two idle edges first: free space trails a pointer write by one cycle
   task automatic ck8(input logic [2:0] s, input logic [7:0] a, e);
      repeat (2) @(posedge clk);
      {rsock, addr, rd} <= {s, a, 1'b1};
      @(posedge clk);
      rd <= 1'b0;
      #1 chk("rvalid", rvalid, 1'b1);
      chk("rdata", rdata, e);
   endtask
   task automatic ck16(input logic [2:0] s, input logic [7:0] a, input logic [15:0] e);
      ck8(s, a, e[15:8]);
      ck8(s, a + 8'h01, e[7:0]);
   endtask
   task automatic bw(input logic [15:0] o, input logic [7:0] d);
      @(posedge clk);
      {bsock, boff, bdata, bwr} <= {3'h1, o, d, 1'b1};
      @(posedge clk);
      bwr <= 1'b0;
   endtask
   task automatic ev(input int k, input logic [2:0] s, input logic [15:0] d);
      @(posedge clk);
      {csock, pmss, ackp} <= {s, d, d};
      {open, send, sync, mss_ld, ack_ld} <= 5'(5'h10 >> k);
      @(posedge clk);
      {open, send, sync, mss_ld, ack_ld} <= 5'h00;
   endtask
   task automatic xmit(input logic [3:0] st);
      int i;
      stall <= st;
      ev(1, 3'h1, 16'h0000);
      i = 0;
      do begin
         @(posedge clk);
         #1 i++;
      end while (done !== 1'b1 && i < 100);
      chk("send_done", done, 1'b1);
      chk("tx_busy", busy, 1'b0);
      chk("ttl_out", ttl, 8'h80);
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_regs();
      chk("ttl_out", ttl, 8'h80);
      foreach (ra[i]) ck8(3'h0, ra[i], re[i]);
      wreg(3'h0, 8'h20, 8'h12);
      ck8(3'h0, 8'h20, 8'h08);
      ev(3, 3'h0, 16'h1234);
      ck16(3'h0, 8'h12, 16'h1234);
   endtask
   task automatic t_sizes();
      foreach (codes[i]) begin
         wreg(3'h3, 8'h1e, codes[i]);
         ck8(3'h3, 8'h1e, codes[i]);
         wreg(3'h3, 8'h1f, codes[i]);
         ck8(3'h3, 8'h20, 8'(codes[i] * 4));
      end
      wreg(3'h3, 8'h1e, 8'h02);
      wreg(3'h3, 8'h1f, 8'h02);
   endtask
   // Second payload lands at 0x0803, an alias of offset 3 in a 2KB buffer
   task automatic t_send();
      wreg(3'h1, 8'h15, 8'h5a);
      ev(0, 3'h1, 16'h0000);
      for (int i = 0; i < 3; i++) bw(16'(i), 8'(8'ha0 + i));
      w16(3'h1, 8'h24, 16'h0003);
      xmit(4'h0);
      chk("tos_out", tos, 8'h5a);
      ck16(3'h1, 8'h22, 16'h0003);
      ck16(3'h1, 8'h20, 16'h0800);
      bw(16'h0803, 8'hc3);
      w16(3'h1, 8'h24, 16'h0004);
      xmit(4'h3);
      chk("count", 16'(sink.got.size()), 16'h0004);
      foreach (exp_b[i]) chk("stream", sink.got[i], exp_b[i]);
   endtask
   task automatic t_tcp();
      wreg(3'h1, 8'h00, 8'h01);
      ck16(3'h1, 8'h20, 16'h07fc);
      ev(4, 3'h1, 16'h0004);
      ck16(3'h1, 8'h20, 16'h0800);
      ev(2, 3'h1, 16'h0000);
      ck16(3'h1, 8'h22, 16'h0000);
      ck16(3'h1, 8'h24, 16'h0000);
      ev(4, 3'h1, 16'hfffe);
      w16(3'h1, 8'h24, 16'h0002);
      ck16(3'h1, 8'h20, 16'h07fc);
   endtask
   task automatic t_map();
      @(posedge clk);
      {msock, moff, map_req} <= {3'h2, 16'h1805, 1'b1};
      @(posedge clk);
      map_req <= 1'b0;
      #1 chk("map_valid", map_valid, 1'b1);
      chk("map_addr", maddr, 14'h1005);
   endtask
   task automatic summarize();
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      t_regs();
      t_sizes();
      t_send();
      t_tcp();
      t_map();
      summarize();
   end
   // The whole run takes about two hundred and twenty cycles
   initial begin
      #100000;
      error_cnt++;
      summarize();
   end
endmodule // sbt_socket_buffer_bench
`default_nettype wire

// ### bench/sbt_stream_sink.sv
// Purpose: Stream sink standing in for the transmit path behind the block
// Assumes: Byte handshake on valid and ready, one clock
// Notes: Waits stall_in cycles of valid before taking a byte
`timescale 1ns/100ps
`default_nettype none
module sbt_stream_sink (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic [7:0] data_in,
   input wire logic valid_in,
   input wire logic [3:0] stall_in,
   output logic ready_out
);
   logic [7:0] got [$];
   logic [3:0] wait_reg;
   // Ready pulses for one cycle only, so a held byte is never taken twice
   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ready_out <= 1'b0;
         wait_reg <= 4'h0;
      end else if (ready_out) begin
         if (valid_in) got.push_back(data_in);
         ready_out <= 1'b0;
         wait_reg <= 4'h0;
      end else if (valid_in) begin
         if (wait_reg >= stall_in) ready_out <= 1'b1;
         else wait_reg <= wait_reg + 4'h1;
      end
   end
endmodule // sbt_stream_sink
`default_nettype wire

// ### src/sbt_defines.svh
// Purpose: Register offsets, reset values and codes of the socket buffer block
// Assumes: Byte-wide register access, upper byte of 16-bit values at the lower offset
// Notes: Definitions only
//
// Functional notes
// - Segment size register; peer value loads in passive TCP
// - Service type byte, resets to zero
// - Time to live byte, resets to 0x80
// - Receive size codes 0,1,2,4,8,16 kilobytes
// - Both buffer size codes reset to two
// - Host keeps receive sizes within 16KB
// - Receive regions packed in socket order
// - Receive offset spans full 16 bits
// - Transmit size codes 0,1,2,4,8,16 kilobytes
// - Host keeps transmit sizes within 16KB
// - Transmit regions packed in socket order
// - Transmit offset spans full 16 bits
// - Free space resets to 0x0800
// - Non-TCP free space uses read pointer
// - TCP free space uses acknowledge pointer
// - Open and TCP connect clear pointers
// - Send streams read to write, then catches up
// - Pointer arithmetic wraps modulo 65536
`ifndef SBT_DEFINES_SVH
`define SBT_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SBT_OFF_MODE 8'h00
`define SBT_OFF_MSS_HI 8'h12
`define SBT_OFF_MSS_LO 8'h13
`define SBT_OFF_TOS 8'h15
`define SBT_OFF_TTL 8'h16
`define SBT_OFF_RXSZ 8'h1e
`define SBT_OFF_TXSZ 8'h1f
`define SBT_OFF_FREE_HI 8'h20
`define SBT_OFF_FREE_LO 8'h21
`define SBT_OFF_TXRD_HI 8'h22
`define SBT_OFF_TXRD_LO 8'h23
`define SBT_OFF_TXWR_HI 8'h24
`define SBT_OFF_TXWR_LO 8'h25

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define SBT_RST_MODE 8'h00
`define SBT_RST_MSS 16'h0000
`define SBT_RST_TOS 8'h00
`define SBT_RST_TTL 8'h80
`define SBT_RST_BUFSZ 8'h02
`define SBT_RST_FREE 16'h0800
`define SBT_RST_PTR 16'h0000
`define SBT_PROTO_TCP 4'h1
`define SBT_PROTO_MSB 3
`define SBT_KB_SHIFT 10

`endif

// ### src/sbt_pkg.sv
// Purpose: Types shared by the socket buffer block
// Assumes: sbt_defines.svh holds the register numbers; the ten-bit kilobyte shift is coded here
// Notes: Size decode keeps the code's low six bits
`include "sbt_defines.svh"
package sbt_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_MAP, ST_READ, ST_EMIT} sbt_send_e;
   typedef logic [15:0] sbt_ptr_t;

   // Size code in kilobytes to bytes
   function automatic sbt_ptr_t sbt_size_bytes(input logic [7:0] code);
      sbt_size_bytes = sbt_ptr_t'({code[5:0], 10'h000});
   endfunction
endpackage

// ### src/sbt_region_map.sv
// Purpose: Map a socket's 16-bit buffer offset to a physical memory address
// Assumes: Sizes are powers of two in kilobytes
// Notes: One cycle latency; sums beyond the memory wrap
`timescale 1ns/100ps
`default_nettype none
module sbt_region_map
   import sbt_pkg::*;
#(
   parameter int N = 8,
   parameter int AW = 14
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic [7:0] sizes_in [N],
   input wire logic req_in,
   input wire logic [$clog2(N)-1:0] sock_in,
   input wire logic [15:0] offset_in,
   output logic [AW-1:0] addr_out,
   output logic valid_out
);
   sbt_ptr_t base [N+1];
   sbt_ptr_t sz;
   sbt_ptr_t phys;

   assign base[0] = 16'h0000;
   for (genvar g = 0; g < N; g++) begin : g_base
      assign base[g+1] = base[g] + sbt_size_bytes(sizes_in[g]);
   end

   assign sz = sbt_size_bytes(sizes_in[sock_in]);
   assign phys = base[sock_in] + (offset_in & (sz - 16'h0001));

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         addr_out <= '0;
         valid_out <= 1'b0;
      end else begin
         addr_out <= phys[AW-1:0];
         valid_out <= req_in;
      end
   end

   chk_map_addr: assert property (@(posedge clk_in) disable iff (!rstn_in)
      req_in |=> addr_out == $past(phys[AW-1:0]))
      else $error("mapped address does not follow base plus offset");
endmodule // sbt_region_map
`default_nettype wire

// ### src/sbt_socket_buffer.sv
// Purpose: Per-socket buffer sizing, transmit pointers, free space and send streaming
// Assumes: Socket events come from same-clock logic; one socket index per cycle
// Notes: Host reaches registers one byte at a time through the serial front end
`timescale 1ns/100ps
`default_nettype none
`include "sbt_defines.svh"
module sbt_socket_buffer
   import sbt_pkg::*;
#(
   parameter int N = 8,
   parameter int AW = 14
) (
   input wire logic core_clk_in,
   input wire logic rstn_in,
   input wire logic [2:0] reg_sock_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   output logic reg_rvalid_out,
   input wire logic [2:0] cmd_sock_in,
   input wire logic cmd_open_in,
   input wire logic cmd_send_in,
   input wire logic tcp_sync_in,
   input wire logic peer_mss_load_in,
   input wire logic [15:0] peer_mss_in,
   input wire logic ack_ptr_load_in,
   input wire logic [15:0] ack_ptr_in,
   input wire logic buf_wr_in,
   input wire logic [2:0] buf_sock_in,
   input wire logic [15:0] buf_offset_in,
   input wire logic [7:0] buf_wdata_in,
   input wire logic rx_map_req_in,
   input wire logic [2:0] rx_map_sock_in,
   input wire logic [15:0] rx_map_offset_in,
   output logic [AW-1:0] rx_map_addr_out,
   output logic rx_map_valid_out,
   output logic [7:0] tx_data_out,
   output logic tx_valid_out,
   input wire logic tx_ready_in,
   output logic tx_busy_out,
   output logic send_done_out,
   output logic [7:0] tx_tos_out,
   output logic [7:0] tx_ttl_out
);
   // ----------------------------------------------------------------
   // Per-socket state
   // ----------------------------------------------------------------
   logic [7:0] mode_reg [N];
   logic [15:0] mss_reg [N];
   logic [7:0] tos_reg [N];
   logic [7:0] ttl_reg [N];
   logic [7:0] rxsz_reg [N];
   logic [7:0] txsz_reg [N];
   sbt_ptr_t free_reg [N];
   sbt_ptr_t tx_rd_reg [N];
   sbt_ptr_t tx_wr_reg [N];
   sbt_ptr_t ack_reg [N];

   sbt_send_e state_reg;
   logic [2:0] send_sock_reg;
   sbt_ptr_t cur_reg;
   sbt_ptr_t end_reg;
   sbt_ptr_t cur_next;
   logic [7:0] buf_data_reg;

   logic wr_hit;
   logic reset_evt;
   logic last_byte;
   logic abort;
   logic fin;
   logic start_ok;
   logic [AW-1:0] bw_addr;
   logic bw_valid;
   logic [AW-1:0] rd_addr;
   logic [7:0] mem_rdata;

   assign wr_hit = reg_wr_in;
   assign reset_evt = cmd_open_in | tcp_sync_in;
   assign cur_next = cur_reg + 16'h0001;
   assign last_byte = (cur_next == end_reg);
   assign abort = reset_evt && (cmd_sock_in == send_sock_reg) && (state_reg != ST_IDLE);
   assign fin = (state_reg == ST_EMIT) && tx_valid_out && tx_ready_in && last_byte && !abort;
   assign start_ok = (state_reg == ST_IDLE) && cmd_send_in && !reset_evt;

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         for (int i = 0; i < N; i++) begin
            mode_reg[i] <= `SBT_RST_MODE;
            tos_reg[i] <= `SBT_RST_TOS;
            ttl_reg[i] <= `SBT_RST_TTL;
            rxsz_reg[i] <= `SBT_RST_BUFSZ;
            txsz_reg[i] <= `SBT_RST_BUFSZ;
         end
      end else if (wr_hit) begin
         unique case (reg_addr_in)
            `SBT_OFF_MODE: mode_reg[reg_sock_in] <= reg_wdata_in;
            `SBT_OFF_TOS: tos_reg[reg_sock_in] <= reg_wdata_in;
            `SBT_OFF_TTL: ttl_reg[reg_sock_in] <= reg_wdata_in;
            `SBT_OFF_RXSZ: rxsz_reg[reg_sock_in] <= reg_wdata_in;
            `SBT_OFF_TXSZ: txsz_reg[reg_sock_in] <= reg_wdata_in;
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Segment size: the peer's value wins over a host write
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         for (int i = 0; i < N; i++) begin
            mss_reg[i] <= `SBT_RST_MSS;
         end
      end else if (peer_mss_load_in) begin
         mss_reg[cmd_sock_in] <= peer_mss_in;
      end else if (wr_hit && reg_addr_in == `SBT_OFF_MSS_HI) begin
         mss_reg[reg_sock_in][15:8] <= reg_wdata_in;
      end else if (wr_hit && reg_addr_in == `SBT_OFF_MSS_LO) begin
         mss_reg[reg_sock_in][7:0] <= reg_wdata_in;
      end
   end

   // ----------------------------------------------------------------
   // Transmit pointers
   // ----------------------------------------------------------------
   // Open and connect clear the socket; the host may still write the
   // write pointer of other sockets in the same cycle.
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         for (int i = 0; i < N; i++) begin
            tx_rd_reg[i] <= `SBT_RST_PTR;
            tx_wr_reg[i] <= `SBT_RST_PTR;
            ack_reg[i] <= `SBT_RST_PTR;
         end
      end else begin
         for (int i = 0; i < N; i++) begin
            if (reset_evt && cmd_sock_in == 3'(i)) begin
               tx_rd_reg[i] <= `SBT_RST_PTR;
               tx_wr_reg[i] <= `SBT_RST_PTR;
               ack_reg[i] <= `SBT_RST_PTR;
            end else begin
               if (fin && send_sock_reg == 3'(i)) begin
                  tx_rd_reg[i] <= end_reg;
               end
               if (ack_ptr_load_in && cmd_sock_in == 3'(i)) begin
                  ack_reg[i] <= ack_ptr_in;
               end
               if (wr_hit && reg_sock_in == 3'(i)) begin
                  if (reg_addr_in == `SBT_OFF_TXWR_HI) begin
                     tx_wr_reg[i][15:8] <= reg_wdata_in;
                  end
                  if (reg_addr_in == `SBT_OFF_TXWR_LO) begin
                     tx_wr_reg[i][7:0] <= reg_wdata_in;
                  end
               end
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Free space, one per socket
   // ----------------------------------------------------------------
   // The host writes the pointer a byte at a time, so free space can
   // glitch between the two writes; reading twice hides that.
   for (genvar g = 0; g < N; g++) begin : g_free
      sbt_ptr_t sz;
      sbt_ptr_t used;
      logic is_tcp;
      assign sz = sbt_size_bytes(txsz_reg[g]);
      assign is_tcp = (mode_reg[g][`SBT_PROTO_MSB:0] == `SBT_PROTO_TCP);
      assign used = is_tcp ? tx_wr_reg[g] - ack_reg[g]
                           : tx_wr_reg[g] - tx_rd_reg[g];
      always_ff @(posedge core_clk_in or negedge rstn_in) begin
         if (!rstn_in) begin
            free_reg[g] <= `SBT_RST_FREE;
         end else begin
            free_reg[g] <= (sz >= used) ? sz - used : 16'h0000;
         end
      end
   end

   // ----------------------------------------------------------------
   // Register readback
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         reg_rdata_out <= 8'h00;
         reg_rvalid_out <= 1'b0;
      end else begin
         reg_rvalid_out <= reg_rd_in;
         if (reg_rd_in) begin
            unique case (reg_addr_in)
               `SBT_OFF_MODE: reg_rdata_out <= mode_reg[reg_sock_in];
               `SBT_OFF_MSS_HI: reg_rdata_out <= mss_reg[reg_sock_in][15:8];
               `SBT_OFF_MSS_LO: reg_rdata_out <= mss_reg[reg_sock_in][7:0];
               `SBT_OFF_TOS: reg_rdata_out <= tos_reg[reg_sock_in];
               `SBT_OFF_TTL: reg_rdata_out <= ttl_reg[reg_sock_in];
               `SBT_OFF_RXSZ: reg_rdata_out <= rxsz_reg[reg_sock_in];
               `SBT_OFF_TXSZ: reg_rdata_out <= txsz_reg[reg_sock_in];
               `SBT_OFF_FREE_HI: reg_rdata_out <= free_reg[reg_sock_in][15:8];
               `SBT_OFF_FREE_LO: reg_rdata_out <= free_reg[reg_sock_in][7:0];
               `SBT_OFF_TXRD_HI: reg_rdata_out <= tx_rd_reg[reg_sock_in][15:8];
               `SBT_OFF_TXRD_LO: reg_rdata_out <= tx_rd_reg[reg_sock_in][7:0];
               `SBT_OFF_TXWR_HI: reg_rdata_out <= tx_wr_reg[reg_sock_in][15:8];
               `SBT_OFF_TXWR_LO: reg_rdata_out <= tx_wr_reg[reg_sock_in][7:0];
               default: reg_rdata_out <= 8'h00;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Host path into the transmit memory
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         buf_data_reg <= 8'h00;
      end else if (buf_wr_in) begin
         buf_data_reg <= buf_wdata_in;
      end
   end

   sbt_region_map #(.N(N), .AW(AW)) u_tx_wmap (
      .clk_in(core_clk_in),
      .rstn_in(rstn_in),
      .sizes_in(txsz_reg),
      .req_in(buf_wr_in),
      .sock_in(buf_sock_in),
      .offset_in(buf_offset_in),
      .addr_out(bw_addr),
      .valid_out(bw_valid)
   );

   sbt_region_map #(.N(N), .AW(AW)) u_tx_rmap (
      .clk_in(core_clk_in),
      .rstn_in(rstn_in),
      .sizes_in(txsz_reg),
      .req_in(state_reg == ST_MAP),
      .sock_in(send_sock_reg),
      .offset_in(cur_reg),
      .addr_out(rd_addr),
      .valid_out()
   );

   sbt_region_map #(.N(N), .AW(AW)) u_rx_map (
      .clk_in(core_clk_in),
      .rstn_in(rstn_in),
      .sizes_in(rxsz_reg),
      .req_in(rx_map_req_in),
      .sock_in(rx_map_sock_in),
      .offset_in(rx_map_offset_in),
      .addr_out(rx_map_addr_out),
      .valid_out(rx_map_valid_out)
   );

   sbt_tx_mem #(.AW(AW), .DW(8)) u_tx_mem (
      .clk_in(core_clk_in),
      .wr_en_in(bw_valid),
      .wr_addr_in(bw_addr),
      .wr_data_in(buf_data_reg),
      .rd_en_in(state_reg == ST_READ),
      .rd_addr_in(rd_addr),
      .rd_data_out(mem_rdata)
   );

   // ----------------------------------------------------------------
   // Send engine
   // ----------------------------------------------------------------
   // Four cycles per byte plus the sink's stall; throughput was traded
   // for a single read port and no prefetch buffer.
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state_reg <= ST_IDLE;
         send_sock_reg <= 3'h0;
         cur_reg <= `SBT_RST_PTR;
         end_reg <= `SBT_RST_PTR;
         tx_data_out <= 8'h00;
         tx_valid_out <= 1'b0;
         tx_busy_out <= 1'b0;
         send_done_out <= 1'b0;
         tx_tos_out <= `SBT_RST_TOS;
         tx_ttl_out <= `SBT_RST_TTL;
      end else begin
         send_done_out <= 1'b0;
         unique case (state_reg)
            ST_IDLE: begin
               if (start_ok) begin
                  send_sock_reg <= cmd_sock_in;
                  cur_reg <= tx_rd_reg[cmd_sock_in];
                  end_reg <= tx_wr_reg[cmd_sock_in];
                  tx_tos_out <= tos_reg[cmd_sock_in];
                  tx_ttl_out <= ttl_reg[cmd_sock_in];
                  if (tx_rd_reg[cmd_sock_in] == tx_wr_reg[cmd_sock_in]) begin
                     send_done_out <= 1'b1;
                  end else begin
                     state_reg <= ST_MAP;
                     tx_busy_out <= 1'b1;
                  end
               end
            end
            ST_MAP: state_reg <= ST_READ;
            ST_READ: state_reg <= ST_EMIT;
            ST_EMIT: begin
               if (!tx_valid_out) begin
                  tx_valid_out <= 1'b1;
                  tx_data_out <= mem_rdata;
               end else if (tx_ready_in) begin
                  tx_valid_out <= 1'b0;
                  cur_reg <= cur_next;
                  if (last_byte) begin
                     state_reg <= ST_IDLE;
                     tx_busy_out <= 1'b0;
                     send_done_out <= 1'b1;
                  end else begin
                     state_reg <= ST_MAP;
                  end
               end
            end
         endcase
         if (abort) begin
            state_reg <= ST_IDLE;
            tx_valid_out <= 1'b0;
            tx_busy_out <= 1'b0;
            send_done_out <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rstn_in);

   sequence seq_send_start;
      start_ok && (tx_rd_reg[cmd_sock_in] != tx_wr_reg[cmd_sock_in]);
   endsequence

   sequence seq_first_byte;
      state_reg == ST_MAP ##1 state_reg == ST_READ ##1 state_reg == ST_EMIT ##1 tx_valid_out;
   endsequence

   chk_send_first_byte: assert property (seq_send_start |=> seq_first_byte)
      else $error("send did not present its first byte in four cycles");

   chk_send_catch_up: assert property (fin |=> tx_rd_reg[send_sock_reg] == end_reg)
      else $error("read pointer did not reach write pointer after send");

   chk_open_clears: assert property (cmd_open_in |=>
      tx_rd_reg[$past(cmd_sock_in)] == 16'h0000 && tx_wr_reg[$past(cmd_sock_in)] == 16'h0000)
      else $error("open did not clear transmit pointers");

   chk_ptr_wrap: assert property ((state_reg == ST_EMIT) && tx_valid_out && tx_ready_in
      && cur_reg == 16'hffff && !abort |=> cur_reg == 16'h0000)
      else $error("stream pointer did not wrap to zero");

   chk_peer_mss: assert property (peer_mss_load_in |=>
      mss_reg[$past(cmd_sock_in)] == $past(peer_mss_in))
      else $error("peer segment size not loaded");

   chk_free_udp: assert property ((mode_reg[0][3:0] != 4'h1)
      && (g_free[0].sz >= tx_wr_reg[0] - tx_rd_reg[0])
      |=> free_reg[0] == $past(g_free[0].sz - (tx_wr_reg[0] - tx_rd_reg[0])))
      else $error("non-TCP free space wrong");

   chk_free_tcp: assert property ((mode_reg[0][3:0] == 4'h1)
      && (g_free[0].sz >= tx_wr_reg[0] - ack_reg[0])
      |=> free_reg[0] == $past(g_free[0].sz - (tx_wr_reg[0] - ack_reg[0])))
      else $error("TCP free space wrong");

   chk_ttl_read: assert property (reg_rd_in && reg_addr_in == 8'h16 |=>
      reg_rvalid_out && reg_rdata_out == $past(ttl_reg[reg_sock_in]))
      else $error("time to live readback wrong");

   chk_stream_hold: assert property (tx_valid_out && !tx_ready_in && !abort |=>
      tx_valid_out && $stable(tx_data_out))
      else $error("stream byte dropped while stalled");
endmodule // sbt_socket_buffer
`default_nettype wire

// ### src/sbt_tx_mem.sv
// Purpose: Transmit byte memory shared by all sockets
// Assumes: One write and one read port on the core clock
// Notes: Read data is registered and holds until the next read
`timescale 1ns/100ps
`default_nettype none
module sbt_tx_mem #(
   parameter int AW = 14,
   parameter int DW = 8
) (
   input wire logic clk_in,
   input wire logic wr_en_in,
   input wire logic [AW-1:0] wr_addr_in,
   input wire logic [DW-1:0] wr_data_in,
   input wire logic rd_en_in,
   input wire logic [AW-1:0] rd_addr_in,
   output logic [DW-1:0] rd_data_out
);
   logic [DW-1:0] mem [2**AW];

   always_ff @(posedge clk_in) begin
      if (wr_en_in) begin
         mem[wr_addr_in] <= wr_data_in;
      end
      if (rd_en_in) begin
         rd_data_out <= mem[rd_addr_in];
      end
   end
endmodule // sbt_tx_mem
`default_nettype wire
